// >>> hw/asr_defines.svh
// asr_defines.svh: named constants for the async serial receiver
// assumes inclusion by bare name from files under hw/
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH
`define ASR_OVERSAMPLE 5'h10
`define ASR_OS_LAST 4'hf
`define ASR_HALF_BIT 4'h7
`define ASR_VOTE_FIRST 4'hd
`define ASR_VOTE_MID 4'he
`define ASR_VOTE_LAST 4'hf
`define ASR_BITS_8 4'h8
`define ASR_BITS_9 4'h9
`define ASR_FIFO_DEPTH 2'h2
`define ASR_DIV_W 16
`endif

// >>> hw/asr_pkg.sv
// asr_pkg.sv: types shared by the async serial receiver
// assumes asr_defines.svh alongside
package asr_pkg;
   typedef enum logic [1:0] {
      ASR_IDLE = 2'b00,
      ASR_START = 2'b01,
      ASR_DATA = 2'b10,
      ASR_STOP = 2'b11
   } asr_state_t;

   // one received character with its framing status
   typedef struct packed {
      logic frame_err;
      logic [8:0] data;
   } asr_char_t;

   // enables and mode selects steering the receiver and its interrupt
   typedef struct packed {
      logic serial_port_enable;
      logic continuous_receive_enable;
      logic sync_mode_select;
      logic nine_bit_receive_select;
      logic address_detect_enable;
      logic receive_interrupt_enable;
      logic peripheral_interrupt_enable;
      logic global_interrupt_enable;
   } asr_ctrl_t;

   // status visible to software
   typedef struct packed {
      logic receive_pending_flag;
      logic framing_error_flag;
      logic overrun_error_flag;
      logic received_ninth_bit;
   } asr_status_t;
endpackage

// >>> hw/asr_receiver.sv
// asr_receiver.sv: asynchronous receive path with two-entry fifo
// assumes serial_receive_pin is synchronous to ref_clk and a 16x bit-rate tick from the baud generator
//
// Contract
// R1 - sample line at sixteen times bit rate
// R2 - completed character goes into two-deep fifo
// R3 - fifo only reachable through data register
// R4 - receive only with enables set, sync clear
// R5 - software sets pin direction as input
// R6 - software clears analog select on pin
// R7 - falling edge on idle line starts character
// R8 - confirm start low at half bit
// R9 - high start centre aborts silently, resume hunt
// R10 - sample each data bit per bit, majority
// R11 - sample stop bit one bit later
// R12 - zero stop bit marks framing error
// R13 - push character and raise pending after stop
// R14 - read returns oldest character and pops
// R15 - overrun blocks further characters until cleared
// R16 - pending high when enabled and fifo nonempty
// R17 - pending flag read-only, follows occupancy
// R18 - interrupt needs all three enables plus pending
// R19 - third character with full fifo sets overrun; here a read in the same cycle drops it without overrun
// R20 - framing flag tracks oldest, cleared by port disable
// R21 - nine-bit mode, ninth bit shown for oldest
// R22 - address detect keeps only ninth-bit-set characters
// R23 - data arrives least significant bit first
// R24 - vote over three ticks around midpoint
`include "asr_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module asr_receiver
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sample_tick,
   input wire logic serial_receive_pin,
   input wire asr_pkg::asr_ctrl_t ctrl,
   input wire logic receive_data_read,
   output logic [7:0] receive_data_register,
   output asr_pkg::asr_status_t status,
   output logic receive_interrupt
);
   asr_pkg::asr_state_t state_q;
   logic [3:0] os_cnt_q;
   logic [3:0] bit_cnt_q;
   logic [8:0] receive_shift_register_q;
   logic [1:0] vote_q;
   logic line_q;
   logic push_q;
   logic push_framing_error_flag_q;
   logic overrun_q;
   asr_pkg::asr_char_t fifo_q [0:1];
   logic rd_ptr_q;
   logic wr_ptr_q;
   logic [1:0] count_q;
   logic rx_on;
   logic port_on;
   logic vote_bit;
   logic [3:0] nbits;
   logic pop;
   logic accept;
   asr_pkg::asr_char_t head;

   assign port_on = ctrl.serial_port_enable && !ctrl.sync_mode_select;
   assign rx_on = port_on && ctrl.continuous_receive_enable; // R4
   assign nbits = ctrl.nine_bit_receive_select ? `ASR_BITS_9 : `ASR_BITS_8; // R21
   // two of three wins
   assign vote_bit = (vote_q[0] & vote_q[1]) | (vote_q[0] & serial_receive_pin) | (vote_q[1] & serial_receive_pin); // R24
   assign pop = receive_data_read && (count_q != 2'h0); // R14
   assign head = fifo_q[rd_ptr_q];

   // previous line level for the falling edge detector
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         line_q <= 1'b1;
      else if (sample_tick)
         line_q <= serial_receive_pin;
   end

   // vote window: two ticks held here, the third is the live pin at the shift tick,
   // so all three sit in the middle of the bit and none is stale
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         vote_q <= 2'h3;
      else if (sample_tick && os_cnt_q >= `ASR_VOTE_FIRST && os_cnt_q <= `ASR_VOTE_MID)
         vote_q <= {serial_receive_pin, vote_q[1]}; // R24
   end

   // bit recovery sequence
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= asr_pkg::ASR_IDLE;
         os_cnt_q <= 4'h0;
         bit_cnt_q <= 4'h0;
         receive_shift_register_q <= 9'h000;
         push_q <= 1'b0;
         push_framing_error_flag_q <= 1'b0;
      end
      else if (!rx_on)
      begin
         state_q <= asr_pkg::ASR_IDLE;
         push_q <= 1'b0;
      end
      else
      begin
         push_q <= 1'b0;
         if (sample_tick) // R1
         begin
            case (state_q)
               asr_pkg::ASR_IDLE:
               begin
                  os_cnt_q <= 4'h0;
                  if (line_q && !serial_receive_pin) // R7
                     state_q <= asr_pkg::ASR_START;
               end
               asr_pkg::ASR_START:
               begin
                  os_cnt_q <= os_cnt_q + 4'h1;
                  if (os_cnt_q == `ASR_HALF_BIT)
                  begin
                     os_cnt_q <= 4'h0;
                     bit_cnt_q <= 4'h0;
                     if (serial_receive_pin) // R9
                        state_q <= asr_pkg::ASR_IDLE;
                     else
                        state_q <= asr_pkg::ASR_DATA; // R8
                  end
               end
               asr_pkg::ASR_DATA:
               begin
                  os_cnt_q <= os_cnt_q + 4'h1;
                  if (os_cnt_q == `ASR_OS_LAST)
                  begin
                     // lsb first: shift in at the top, right-justify for 8-bit below
                     receive_shift_register_q <= {vote_bit, receive_shift_register_q[8:1]}; // R10 R23
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                     if (bit_cnt_q + 4'h1 == nbits)
                        state_q <= asr_pkg::ASR_STOP;
                  end
               end
               asr_pkg::ASR_STOP:
               begin
                  os_cnt_q <= os_cnt_q + 4'h1;
                  if (os_cnt_q == `ASR_OS_LAST)
                  begin
                     push_q <= 1'b1; // R11 R13
                     push_framing_error_flag_q <= !vote_bit; // R12
                     state_q <= asr_pkg::ASR_IDLE;
                  end
               end
               default:
                  state_q <= asr_pkg::ASR_IDLE;
            endcase
         end
      end
   end

   // address detection in nine-bit mode drops characters without the ninth bit; overrun stalls the fifo
   assign accept = push_q && !overrun_q && (count_q != `ASR_FIFO_DEPTH) &&
                   !(ctrl.nine_bit_receive_select && ctrl.address_detect_enable &&
                     !receive_shift_register_q[8]); // R22 R15

   // overrun: a same-cycle clear wins over set, since the rx-off branch is checked first
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         overrun_q <= 1'b0;
      else if (!rx_on)
         overrun_q <= 1'b0; // R19
      else if (push_q && count_q == `ASR_FIFO_DEPTH && !pop &&
               !(ctrl.nine_bit_receive_select && ctrl.address_detect_enable && !receive_shift_register_q[8]))
         overrun_q <= 1'b1; // R19
   end

   // fifo storage, one generate lane per entry
   genvar gi;
   generate
      for (gi = 0; gi < `ASR_FIFO_DEPTH; gi++)
      begin : g_entry
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
               fifo_q[gi] <= '0;
            else if (!ctrl.serial_port_enable)
               fifo_q[gi] <= '0; // R20
            else if (accept && wr_ptr_q == 1'(gi))
            begin
               fifo_q[gi].frame_err <= push_framing_error_flag_q;
               fifo_q[gi].data <= ctrl.nine_bit_receive_select ? receive_shift_register_q
                                  : {1'b0, receive_shift_register_q[8:1]}; // R2
            end
         end
      end
   endgenerate

   // pointers and occupancy; a pop in the same cycle does not free room for the push
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_ptr_q <= 1'b0;
         wr_ptr_q <= 1'b0;
         count_q <= 2'h0;
      end
      else if (!ctrl.serial_port_enable)
      begin
         rd_ptr_q <= 1'b0;
         wr_ptr_q <= 1'b0;
         count_q <= 2'h0;
      end
      else
      begin
         if (pop)
            rd_ptr_q <= ~rd_ptr_q; // R14
         if (accept)
            wr_ptr_q <= ~wr_ptr_q; // R2
         count_q <= count_q + {1'b0, accept} - {1'b0, pop};
      end
   end

   // data output registered; the only other paths out of the fifo are the ninth bit and framing flag in status
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         receive_data_register <= 8'h00;
      else
         receive_data_register <= head.data[7:0]; // R3
   end

   assign status.receive_pending_flag = rx_on && (count_q != 2'h0); // R16 R17
   assign status.framing_error_flag = (count_q != 2'h0) && head.frame_err; // R20
   assign status.received_ninth_bit = (count_q != 2'h0) && head.data[8]; // R21
   assign status.overrun_error_flag = overrun_q; // R19
   assign receive_interrupt = status.receive_pending_flag && ctrl.receive_interrupt_enable &&
                              ctrl.peripheral_interrupt_enable && ctrl.global_interrupt_enable; // R18

   fifo_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
      count_q <= `ASR_FIFO_DEPTH)
      else $error("fifo count above depth");

   tick_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
      !sample_tick
      |=> $stable(os_cnt_q) && $stable(bit_cnt_q) && $stable(receive_shift_register_q))
      else $error("line logic moved without a tick");

   edge_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
      (rx_on && sample_tick && state_q == asr_pkg::ASR_IDLE && line_q && !serial_receive_pin)
      |=> state_q == asr_pkg::ASR_START)
      else $error("falling edge did not start a character");

   start_confirm_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
      (rx_on && sample_tick && state_q == asr_pkg::ASR_START && os_cnt_q == `ASR_HALF_BIT &&
       !serial_receive_pin)
      |=> state_q == asr_pkg::ASR_DATA)
      else $error("low start centre not accepted");

   start_abort_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
      (rx_on && sample_tick && state_q == asr_pkg::ASR_START && os_cnt_q == `ASR_HALF_BIT && serial_receive_pin)
      |=> state_q == asr_pkg::ASR_IDLE && !push_q)
      else $error("high start centre not aborted");

   vote_centre_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R24
      (sample_tick && os_cnt_q == `ASR_VOTE_FIRST)
      |=> vote_q[1] == $past(serial_receive_pin))
      else $error("vote sample not taken near bit centre");

   shift_in_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
      (rx_on && sample_tick && state_q == asr_pkg::ASR_DATA && os_cnt_q == `ASR_OS_LAST)
      |=> receive_shift_register_q[8] == $past(vote_bit))
      else $error("voted bit not shifted in");

   stop_frame_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
      (rx_on && sample_tick && state_q == asr_pkg::ASR_STOP && os_cnt_q == `ASR_OS_LAST)
      |=> push_q && (push_framing_error_flag_q != $past(vote_bit)))
      else $error("stop bit framing status wrong");

   pending_track_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
      status.receive_pending_flag == (rx_on && count_q != 2'h0))
      else $error("pending flag mismatch");

   push_raise_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
      (accept && rx_on) |=> status.receive_pending_flag)
      else $error("push did not raise pending");

   pend_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R17
      (count_q == 2'h1 && pop && !accept && ctrl.serial_port_enable)
      |=> !status.receive_pending_flag)
      else $error("pending stayed after last read");

   overrun_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R19
      (rx_on && push_q && count_q == `ASR_FIFO_DEPTH && !pop && !ctrl.address_detect_enable)
      |=> overrun_q || !rx_on)
      else $error("overrun not flagged");

   overrun_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R19
      !rx_on |=> !overrun_q)
      else $error("overrun kept while receiver off");

   overrun_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R15
      overrun_q |-> !accept)
      else $error("character accepted during overrun");

   overrun_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R15
      (overrun_q && rx_on) |=> overrun_q)
      else $error("overrun dropped while enabled");

   irq_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R18
      receive_interrupt |-> ctrl.global_interrupt_enable && ctrl.peripheral_interrupt_enable &&
      ctrl.receive_interrupt_enable && status.receive_pending_flag)
      else $error("ungated interrupt");

   irq_when_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R18
      (ctrl.global_interrupt_enable && ctrl.peripheral_interrupt_enable &&
       ctrl.receive_interrupt_enable && status.receive_pending_flag) |-> receive_interrupt)
      else $error("enabled interrupt missing");

   pop_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
      (pop && !accept && ctrl.serial_port_enable) |=> count_q == $past(count_q) - 2'h1)
      else $error("read did not pop");

   fifo_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R20
      !ctrl.serial_port_enable |=> count_q == 2'h0 && !status.framing_error_flag)
      else $error("port disable left fifo or framing flag");

   ninth_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R21
      (accept && !ctrl.nine_bit_receive_select && count_q == 2'h0)
      |=> !status.received_ninth_bit)
      else $error("ninth bit shown in eight-bit mode");

   addr_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R22
      (push_q && ctrl.nine_bit_receive_select && ctrl.address_detect_enable && !receive_shift_register_q[8])
      |-> !accept)
      else $error("non-address character stored");

   addr_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R22
      (push_q && rx_on && !overrun_q && count_q == 2'h0 && ctrl.nine_bit_receive_select &&
       ctrl.address_detect_enable && receive_shift_register_q[8])
      |=> status.receive_pending_flag || !rx_on)
      else $error("address character not stored");

   disabled_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
      !rx_on |=> state_q == asr_pkg::ASR_IDLE)
      else $error("receiver ran while disabled");

   char_rx_c: cover property (@(posedge ref_clk) disable iff (!rst_n) accept);
   framing_error_flag_c: cover property (@(posedge ref_clk) disable iff (!rst_n) accept && push_framing_error_flag_q);
   overrun_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(overrun_q));
   abort_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      state_q == asr_pkg::ASR_START ##1 state_q == asr_pkg::ASR_IDLE);
   nine_c: cover property (@(posedge ref_clk) disable iff (!rst_n) accept && ctrl.nine_bit_receive_select);
endmodule // asr_receiver
`default_nettype wire

// >>> tb/asr_tx_model.sv
// asr_tx_model.sv: remote asynchronous transmitter driving the receive line
// assumes sample_tick is a one-cycle 16x bit-rate pulse changed on the falling clock edge
`timescale 1ns/10ps
`default_nettype none
module asr_tx_model
(
   input wire logic ref_clk,
   input wire logic sample_tick,
   output logic line
);
   initial line = 1'b1;
   task automatic ticks(input int n);
      repeat (n)
      begin
         @(posedge ref_clk);
         while (sample_tick !== 1'b1) @(posedge ref_clk);
      end
      @(negedge ref_clk);
   endtask
   // short_start drops the line for a pulse that is gone before the start bit centre
   task automatic send(input logic [8:0] d, input int nbits, input logic stop_lvl, input logic short_start);
      line = 1'b0;
      if (short_start)
      begin
         ticks(4);
         line = 1'b1;
         ticks(24);
      end
      else
      begin
         ticks(16);
         for (int i = 0; i < nbits; i++)
         begin
            line = d[i];
            ticks(16);
         end
         line = stop_lvl;
         ticks(16);
         line = 1'b1;
         ticks(3);
      end
   endtask
endmodule // asr_tx_model
`default_nettype wire

// >>> tb/testbench.sv
// testbench.sv: self-checking bench for the async serial receiver
// assumes asr_tx_model on the line; the 16x tick is made here every fourth clock
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic ref_clk;
   logic rst_n;
   logic sample_tick;
   logic line;
   logic receive_data_read;
   logic [1:0] tick_cnt;
   logic [7:0] receive_data_register;
   logic receive_interrupt;
   asr_pkg::asr_ctrl_t ctrl;
   asr_pkg::asr_status_t status;
   int err_count;
   int checked;
   int seed;
   logic [8:0] d0;
   logic [8:0] d1;
   asr_receiver uut (.ref_clk(ref_clk), .rst_n(rst_n), .sample_tick(sample_tick), .serial_receive_pin(line),
      .ctrl(ctrl), .receive_data_read(receive_data_read), .receive_data_register(receive_data_register),
      .status(status), .receive_interrupt(receive_interrupt));
   asr_tx_model tx (.ref_clk(ref_clk), .sample_tick(sample_tick), .line(line));
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   always @(negedge ref_clk)
   begin
      tick_cnt <= tick_cnt + 2'h1;
      sample_tick <= (tick_cnt == 2'h3);
   end
   task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask
   function automatic logic exp_irq(input asr_pkg::asr_ctrl_t c, input logic pend);
      return c.receive_interrupt_enable & c.peripheral_interrupt_enable & c.global_interrupt_enable & pend;
   endfunction
   function automatic logic [8:0] exp_char(input logic [8:0] d, input logic nine);
      return nine ? d : {1'b0, d[7:0]};
   endfunction
   // look at the oldest character and its status, then pop it
   task automatic take(input logic [8:0] d, input logic fe);
      chk_bit(status.receive_pending_flag, 1'b1);
      chk_val({status.received_ninth_bit, receive_data_register}, exp_char(d, ctrl.nine_bit_receive_select));
      chk_bit(status.framing_error_flag, fe);
      receive_data_read = 1'b1;
      @(negedge ref_clk);
      receive_data_read = 1'b0;
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic final_report();
      $display("mismatches %0d, comparisons %0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // nearly four times the expected run
   initial
   begin
      #2400000;
      err_count++;
      final_report();
   end
   initial
   begin
      seed = 32'h652f65ea;
      err_count = 0;
      checked = 0;
      rst_n = 1'b0;
      tick_cnt = 2'h0;
      sample_tick = 1'b0;
      receive_data_read = 1'b0;
      ctrl = '0;
      repeat (4) @(negedge ref_clk);
      rst_n = 1'b1;
      chk_val({4'h0, status, receive_interrupt}, 9'h000);
      // pin taken as a digital input by software
      ctrl.serial_port_enable = 1'b1;
      ctrl.continuous_receive_enable = 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         d0 = (i == 0) ? 9'h0ff : 9'($random(seed)) & 9'h0ff;
         d1 = (i == 0) ? 9'h000 : 9'($random(seed)) & 9'h0ff;
         tx.send(d0, 8, 1'b1, 1'b0);
         tx.send(d1, 8, 1'b1, 1'b0);
         take(d0, 1'b0);
         take(d1, 1'b0);
         chk_bit(status.receive_pending_flag, 1'b0);
      end
      tx.send(9'h0a5, 8, 1'b0, 1'b0);
      tx.send(9'h05a, 8, 1'b1, 1'b0);
      take(9'h0a5, 1'b1);
      take(9'h05a, 1'b0);
      tx.send(9'h0c3, 8, 1'b0, 1'b0);
      ctrl.serial_port_enable = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk_bit(status.framing_error_flag, 1'b0);
      ctrl.serial_port_enable = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk_bit(status.receive_pending_flag, 1'b0);
      tx.send(9'h000, 8, 1'b1, 1'b1);
      chk_bit(status.receive_pending_flag, 1'b0);
      for (int i = 0; i < 4; i++)
         tx.send(9'(8'h30 + i), 8, 1'b1, 1'b0);
      chk_bit(status.overrun_error_flag, 1'b1);
      take(9'h030, 1'b0);
      take(9'h031, 1'b0);
      chk_bit(status.receive_pending_flag, 1'b0);
      chk_bit(status.overrun_error_flag, 1'b1);
      ctrl.continuous_receive_enable = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk_bit(status.overrun_error_flag, 1'b0);
      for (int i = 0; i < 3; i++)
      begin
         ctrl.continuous_receive_enable = (i != 0);
         ctrl.sync_mode_select = (i == 1);
         ctrl.serial_port_enable = (i != 2);
         tx.send(9'h0c3, 8, 1'b1, 1'b0);
         ctrl.continuous_receive_enable = 1'b1;
         ctrl.sync_mode_select = 1'b0;
         ctrl.serial_port_enable = 1'b1;
         repeat (2) @(negedge ref_clk);
         chk_bit(status.receive_pending_flag, 1'b0);
      end
      tx.send(9'h0e7, 8, 1'b1, 1'b0);
      for (int k = 0; k < 8; k++)
      begin
         {ctrl.receive_interrupt_enable, ctrl.peripheral_interrupt_enable, ctrl.global_interrupt_enable} = 3'(k);
         @(negedge ref_clk);
         chk_bit(receive_interrupt, exp_irq(ctrl, 1'b1));
         chk_bit(status.receive_pending_flag, 1'b1);
      end
      take(9'h0e7, 1'b0);
      chk_bit(receive_interrupt, 1'b0);
      ctrl.nine_bit_receive_select = 1'b1;
      tx.send(9'h1a5, 9, 1'b1, 1'b0);
      take(9'h1a5, 1'b0);
      ctrl.address_detect_enable = 1'b1;
      tx.send(9'h033, 9, 1'b1, 1'b0);
      tx.send(9'h144, 9, 1'b1, 1'b0);
      take(9'h144, 1'b0);
      chk_bit(status.receive_pending_flag, 1'b0);
      final_report();
   end
endmodule // testbench
`default_nettype wire
